/* sicr_clk_mux.sv */
// Clock-output source selector and disable
`timescale 1ns/1ns
`default_nettype none
module sicr_clk_mux #(
  parameter int NSRC = 32
) (
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic             clk_en_in,
  input  wire logic [NSRC-1:0]  clk_src_in,
  input  wire sicr_pkg::sicr_src_t sel_in,
  input  wire logic             dis_in,
  output logic                  clk_o_out,
  output logic                  clk_oe_out
);
  logic pick_d;
  logic pick_q;
  logic oe_d;
  logic oe_q;
  // ==========================================================
  // Selection
  always_comb begin
    pick_d = pick_q;
    oe_d   = oe_q;
    if (!rst_b_in) begin
      pick_d = 1'b0;
      oe_d   = 1'b0;
    end else if (clk_en_in) begin
      pick_d = clk_src_in[sel_in];
      oe_d   = ~dis_in;
    end
  end
  always_ff @(posedge clock_in) begin
    pick_q <= pick_d;
    oe_q   <= oe_d;
  end
  assign clk_o_out  = pick_q;
  assign clk_oe_out = oe_q;
endmodule : sicr_clk_mux
`default_nettype wire

/* sicr_map.svh */
// Register offsets, field positions, reset values and functional notes for the config bank
// Functional notes
// - Sixteen-bit scratch register, fully read/write, cleared only by power-on reset.
// - Scratch keeps its value across pin, software and watchdog resets.
// - Read-only upper half of boundary-scan identification code; writes ignored.
// - Read-only lower half of boundary-scan identification code; writes ignored.
// - Setting a group's pullup-disable bit turns off that group's on-chip pullups.
// - Pullups of GPIO-capable pins stay under GPIO logic control, not this register.
// - Pullup-disable bit 5 covers write/read strobes; bit 3 covers scan TRST, TMS, TDI.
// - Reserved pullup-disable and clock-select bits read zero and ignore writes.
// - Clock-select register routes any one internal clock to the clock output pin.
// - After reset the clock output is disabled: clock-select resets to bit 5 set, source 0.
// - Port-B peripheral enable overrides clock-select; GPIO wins on pins 7 to 4.
// - Per-pin clock-select bits choose address line or extra clock for port-B 7..4.
// - After reset port-B pins 7 to 4 carry address lines 23 to 20.
// - Clock-select bit 9 low makes port-B pin 7 output address line 23.
`ifndef SICR_MAP_SVH
`define SICR_MAP_SVH
// ==========================================================
// Register offsets
`define SICR_OFS_SCRATCH   4'h2
`define SICR_OFS_ID_HIGH   4'h6
`define SICR_OFS_ID_LOW    4'h7
`define SICR_OFS_PULLUP    4'h8
`define SICR_OFS_CLKSEL    4'hA
// ==========================================================
// Fields
`define SICR_PU_STROBE_BIT 5
`define SICR_PU_SCAN_BIT   3
`define SICR_PU_MASK       16'h0028
`define SICR_CK_MASK       16'h03FF
`define SICR_CK_DIS_BIT    5
`define SICR_CK_SRC_HI     4
`define SICR_CK_SRC_LO     0
`define SICR_CK_ALT_HI     9
`define SICR_CK_ALT_LO     6
// ==========================================================
// Reset values
`define SICR_RST_SCRATCH   16'h0000
`define SICR_RST_PULLUP    16'h0000
`define SICR_RST_CLKSEL    16'h0020
`endif

/* sicr_pkg.sv */
// Types shared by the configuration bank
package sicr_pkg;
  typedef logic [15:0] sicr_word_t;
  typedef logic [4:0]  sicr_src_t;
endpackage : sicr_pkg

/* sicr_portb_mux.sv */
// Port-B upper pin function selector
`timescale 1ns/1ns
`default_nettype none
module sicr_portb_mux (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  input  wire logic [3:0] per_en_in,
  input  wire logic [3:0] alt_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [3:0] xclk_in,
  input  wire logic [3:0] gpio_in,
  output logic      [3:0] pin_out
);
  logic [3:0] pin_d;
  logic [3:0] pin_q;
  // ==========================================================
  // Per-pin function
  always_comb begin
    pin_d = pin_q;
    if (!rst_b_in) begin
      pin_d = 4'h0;
    end else if (clk_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (!per_en_in[i]) begin
          pin_d[i] = gpio_in[i];
        end else begin
          pin_d[i] = alt_in[i] ? xclk_in[i] : addr_in[i];
        end
      end
    end
  end
  always_ff @(posedge clock_in) begin
    pin_q <= pin_d;
  end
  assign pin_out = pin_q;
endmodule : sicr_portb_mux
`default_nettype wire

/* sicr_regs.sv */
// System integration configuration register bank
`include "sicr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sicr_regs #(
  parameter sicr_pkg::sicr_word_t ID_HIGH = 16'h0A5A,  // Arbitrary value
  parameter sicr_pkg::sicr_word_t ID_LOW  = 16'h5A5B,  // Arbitrary value
  parameter int                   NSRC    = 32
) (
  input  wire logic                clock_in,
  input  wire logic                rst_b_in,
  input  wire logic                por_b_in,
  input  wire logic                clk_en_in,
  input  wire logic [3:0]          addr_in,
  input  wire sicr_pkg::sicr_word_t wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  input  wire logic [NSRC-1:0]     clk_src_in,
  input  wire logic [3:0]          portb_per_en_in,
  input  wire logic [3:0]          portb_gpio_in,
  input  wire logic [3:0]          addr_hi_in,
  input  wire logic [3:0]          xclk_in,
  output sicr_pkg::sicr_word_t     rdata_out,
  output logic                     pu_strobe_dis_out,
  output logic                     pu_scan_dis_out,
  output logic                     clk_o_out,
  output logic                     clk_oe_out,
  output logic [3:0]               portb_pin_out
);
  sicr_pkg::sicr_word_t scratch_d;
  sicr_pkg::sicr_word_t scratch_q;
  sicr_pkg::sicr_word_t pullup_d;
  sicr_pkg::sicr_word_t pullup_q;
  sicr_pkg::sicr_word_t clksel_d;
  sicr_pkg::sicr_word_t clksel_q;
  sicr_pkg::sicr_word_t rdata_d;
  sicr_pkg::sicr_word_t rdata_q;
  logic                 rst_any_b;

  assign rst_any_b = rst_b_in & por_b_in;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================
  // Scratch, power-on reset only
  always_comb begin
    scratch_d = scratch_q;
    if (!por_b_in) begin
      scratch_d = `SICR_RST_SCRATCH;
    end else if (clk_en_in && wr_in && hit(addr_in, `SICR_OFS_SCRATCH)) begin
      scratch_d = wdata_in;
    end
  end
  always_ff @(posedge clock_in) begin
    scratch_q <= scratch_d;
  end

  // ==========================================================
  // Pullup disable and clock select
  always_comb begin
    pullup_d = pullup_q;
    clksel_d = clksel_q;
    if (!rst_any_b) begin
      pullup_d = `SICR_RST_PULLUP;
      clksel_d = `SICR_RST_CLKSEL;
    end else if (clk_en_in && wr_in) begin
      if (hit(addr_in, `SICR_OFS_PULLUP)) begin
        pullup_d = wdata_in & `SICR_PU_MASK;
      end
      if (hit(addr_in, `SICR_OFS_CLKSEL)) begin
        clksel_d = wdata_in & `SICR_CK_MASK;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    pullup_q <= pullup_d;
    clksel_q <= clksel_d;
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (clk_en_in && rd_in && rst_any_b) begin
      unique case (addr_in)
        `SICR_OFS_SCRATCH: rdata_d = scratch_q;
        `SICR_OFS_ID_HIGH: rdata_d = ID_HIGH;
        `SICR_OFS_ID_LOW:  rdata_d = ID_LOW;
        `SICR_OFS_PULLUP:  rdata_d = pullup_q;
        `SICR_OFS_CLKSEL:  rdata_d = clksel_q;
        default:           rdata_d = 16'h0000;
      endcase
    end else if (!clk_en_in && rst_any_b) begin
      rdata_d = rdata_q;
    end
  end
  always_ff @(posedge clock_in) begin
    rdata_q <= rdata_d;
  end
  assign rdata_out = rdata_q;

  // ==========================================================
  // Pullup controls; GPIO pins are not driven from here
  logic pu_strobe_d;
  logic pu_strobe_q;
  logic pu_scan_d;
  logic pu_scan_q;
  always_comb begin
    pu_strobe_d = pu_strobe_q;
    pu_scan_d   = pu_scan_q;
    if (!rst_any_b) begin
      pu_strobe_d = 1'b0;
      pu_scan_d   = 1'b0;
    end else if (clk_en_in) begin
      pu_strobe_d = pullup_q[`SICR_PU_STROBE_BIT];
      pu_scan_d   = pullup_q[`SICR_PU_SCAN_BIT];
    end
  end
  always_ff @(posedge clock_in) begin
    pu_strobe_q <= pu_strobe_d;
    pu_scan_q   <= pu_scan_d;
  end
  assign pu_strobe_dis_out = pu_strobe_q;
  assign pu_scan_dis_out   = pu_scan_q;

  // ==========================================================
  // Output muxes
  sicr_clk_mux #(
    .NSRC (NSRC)
  ) u_clk_mux (
    .clock_in   (clock_in),
    .rst_b_in   (rst_any_b),
    .clk_en_in  (clk_en_in),
    .clk_src_in (clk_src_in),
    .sel_in     (clksel_q[`SICR_CK_SRC_HI:`SICR_CK_SRC_LO]),
    .dis_in     (clksel_q[`SICR_CK_DIS_BIT]),
    .clk_o_out  (clk_o_out),
    .clk_oe_out (clk_oe_out)
  );

  sicr_portb_mux u_portb_mux (
    .clock_in  (clock_in),
    .rst_b_in  (rst_any_b),
    .clk_en_in (clk_en_in),
    .per_en_in (portb_per_en_in),
    .alt_in    (clksel_q[`SICR_CK_ALT_HI:`SICR_CK_ALT_LO]),
    .addr_in   (addr_hi_in),
    .xclk_in   (xclk_in),
    .gpio_in   (portb_gpio_in),
    .pin_out   (portb_pin_out)
  );
endmodule : sicr_regs
`default_nettype wire

/* sicr_regs_monitor.sv */
// Port-level assertions for the configuration bank
`include "sicr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sicr_regs_monitor #(
  parameter sicr_pkg::sicr_word_t ID_HIGH = 16'h0000,
  parameter sicr_pkg::sicr_word_t ID_LOW  = 16'h0000
) (
  input wire logic                 clock_in,
  input wire logic                 rst_b_in,
  input wire logic                 por_b_in,
  input wire logic                 clk_en_in,
  input wire logic [3:0]           addr_in,
  input wire sicr_pkg::sicr_word_t wdata_in,
  input wire logic                 wr_in,
  input wire logic                 rd_in,
  input wire logic [3:0]           portb_per_en_in,
  input wire logic [3:0]           portb_gpio_in,
  input wire logic [3:0]           addr_hi_in,
  input wire sicr_pkg::sicr_word_t rdata_out,
  input wire logic                 pu_strobe_dis_out,
  input wire logic                 pu_scan_dis_out,
  input wire logic                 clk_oe_out,
  input wire logic [3:0]           portb_pin_out
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in || !por_b_in);
  wire logic ok = rst_b_in && por_b_in && clk_en_in;
  sequence s_rd(a); rd_in && clk_en_in && addr_in == a; endsequence
  sequence s_wr(a); wr_in && clk_en_in && addr_in == a ##1 ok; endsequence
  property p_id_hi; s_rd(`SICR_OFS_ID_HIGH) |=> rdata_out == ID_HIGH; endproperty
  a_id_hi: assert property (p_id_hi) else $error("id high read wrong");
  property p_id_lo; s_rd(`SICR_OFS_ID_LOW) |=> rdata_out == ID_LOW; endproperty
  a_id_lo: assert property (p_id_lo) else $error("id low read wrong");
  property p_rsv_ck; s_rd(`SICR_OFS_CLKSEL) |=> rdata_out[15:10] == 6'h00; endproperty
  a_rsv_ck: assert property (p_rsv_ck) else $error("clock select spare bits set");
  property p_rsv_pu; s_rd(`SICR_OFS_PULLUP) |=> (rdata_out & 16'h0057) == 16'h0000; endproperty
  a_rsv_pu: assert property (p_rsv_pu) else $error("pullup spare bits set");
  property p_pu;
    s_wr(`SICR_OFS_PULLUP) |=>
      {pu_strobe_dis_out, 1'b0, pu_scan_dis_out, 3'h0} == ($past(wdata_in, 2) & 16'h0028);
  endproperty
  a_pu: assert property (p_pu) else $error("pullup outputs wrong");
  property p_oe;
    s_wr(`SICR_OFS_CLKSEL) |=> {clk_oe_out, 5'h00} == (~$past(wdata_in, 2) & 16'h0020);
  endproperty
  a_oe: assert property (p_oe) else $error("clock enable wrong");
  property p_oe_rst; !$past(rst_b_in) || !$past(por_b_in) |-> !clk_oe_out; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("clock driven in reset");
  property p_gpio;
    $past(ok) |-> ((portb_pin_out ^ $past(portb_gpio_in)) & ~$past(portb_per_en_in)) == 4'h0;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pin wrong");
  property p_a_rst;
    (!$past(rst_b_in, 2) || !$past(por_b_in, 2)) && $past(ok) |->
      ((portb_pin_out ^ $past(addr_hi_in)) & $past(portb_per_en_in)) == 4'h0;
  endproperty
  a_a_rst: assert property (p_a_rst) else $error("address pin wrong");
endmodule : sicr_regs_monitor
bind sicr_regs sicr_regs_monitor #(.ID_HIGH(ID_HIGH), .ID_LOW(ID_LOW)) u_mon (.clock_in,
  .rst_b_in, .por_b_in, .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in, .portb_per_en_in,
  .portb_gpio_in, .addr_hi_in, .rdata_out, .pu_strobe_dis_out, .pu_scan_dis_out, .clk_oe_out,
  .portb_pin_out);
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the configuration bank
`include "sicr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam sicr_pkg::sicr_word_t ID_H = 16'h3C96;  // Arbitrary value
  localparam sicr_pkg::sicr_word_t ID_L = 16'h9C3A;  // Arbitrary value
  logic clock_in = 1'b0, rst_b_in = 1'b0, por_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic rd_d = 1'b0, clk_en = 1'b1, pu_st, pu_sc, ck_o, ck_oe;
  logic [3:0] addr_in = 4'h0, per_en = 4'hF, gpio = 4'h0, ahi = 4'h0, xck = 4'h0, pin, pe;
  logic [31:0] src = 32'h0;
  sicr_pkg::sicr_word_t wdata_in = 16'h0000, rdata_out, v, s;
  sicr_pkg::sicr_word_t exp_q[$];
  int err_total = 0, tests_run = 0;
  integer seed = 32'h4C39;
  always #5 clock_in = ~clock_in;
  sicr_regs #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) u_dut (.clock_in, .rst_b_in, .por_b_in,
    .clk_en_in(clk_en), .addr_in, .wdata_in, .wr_in, .rd_in, .clk_src_in(src),
    .portb_per_en_in(per_en), .portb_gpio_in(gpio), .addr_hi_in(ahi), .xclk_in(xck),
    .rdata_out, .pu_strobe_dis_out(pu_st), .pu_scan_dis_out(pu_sc), .clk_o_out(ck_o),
    .clk_oe_out(ck_oe), .portb_pin_out(pin));
  // ==========================================================
  // Tasks
  task automatic check(input sicr_pkg::sicr_word_t got, input sicr_pkg::sicr_word_t exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input int w, input logic [3:0] a, input sicr_pkg::sicr_word_t d);
    @(posedge clock_in);
    wr_in <= (w != 0);
    rd_in <= (w == 0);
    addr_in <= a;
    wdata_in <= d;
    if (w == 0) exp_q.push_back(d);
  endtask : bus
  task automatic idle(input int n);
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clock_in);
    #1;
  endtask : idle
  task automatic rst(input logic por);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    por_b_in <= !por;
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    por_b_in <= 1'b1;
  endtask : rst
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Read-data watcher
  always @(posedge clock_in) begin
    if (rd_d) check(rdata_out, exp_q.pop_front());
    rd_d <= rd_in;
  end
  // ==========================================================
  // Scenarios
  initial begin
    src <= $random(seed);
    ahi <= 4'($random(seed));
    gpio <= 4'($random(seed));
    rst(1'b1);
    bus(0, `SICR_OFS_SCRATCH, 16'h0000);
    bus(0, `SICR_OFS_ID_HIGH, ID_H);
    bus(0, `SICR_OFS_ID_LOW, ID_L);
    bus(0, `SICR_OFS_PULLUP, 16'h0000);
    bus(0, `SICR_OFS_CLKSEL, 16'h0020);
    bus(0, 4'hF, 16'h0000);
    idle(2);
    check(16'(ck_oe), 16'h0000);
    check(16'(pin), 16'(ahi));
    s = 16'($random(seed));
    bus(1, `SICR_OFS_SCRATCH, s);
    bus(1, `SICR_OFS_ID_HIGH, ~ID_H);
    bus(1, `SICR_OFS_ID_LOW, ~ID_L);
    bus(0, `SICR_OFS_SCRATCH, s);
    bus(0, `SICR_OFS_ID_HIGH, ID_H);
    bus(0, `SICR_OFS_ID_LOW, ID_L);
    idle(1);
    rst(1'b0);
    bus(0, `SICR_OFS_SCRATCH, s);
    bus(1, `SICR_OFS_SCRATCH, ~s);
    clk_en <= 1'b0;
    idle(1);
    bus(0, `SICR_OFS_SCRATCH, s);
    clk_en <= 1'b1;
    idle(1);
    rst(1'b1);
    bus(0, `SICR_OFS_SCRATCH, 16'h0000);
    repeat (6) begin
      v = 16'($random(seed));
      bus(1, `SICR_OFS_PULLUP, v);
      bus(0, `SICR_OFS_PULLUP, v & 16'h0028);
      idle(2);
      check(16'({pu_st, pu_sc}), 16'({v[5], v[3]}));
    end
    repeat (10) begin
      v = 16'($random(seed));
      bus(1, `SICR_OFS_CLKSEL, v);
      per_en <= 4'($random(seed));
      gpio <= 4'($random(seed));
      ahi <= 4'($random(seed));
      xck <= 4'($random(seed));
      bus(0, `SICR_OFS_CLKSEL, v & 16'h03FF);
      idle(2);
      check(16'(ck_oe), 16'(!v[5]));
      if (!v[5]) check(16'(ck_o), 16'(src[v[4:0]]));
      pe = (per_en & ((~v[9:6] & ahi) | (v[9:6] & xck))) | (~per_en & gpio);
      check(16'(pin), 16'(pe));
    end
    idle(1);
    close_out();
  end
  initial begin
    #20000;
    err_total++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
